// ===== logic/ssl_ctrl.sv
// spindle speed loop: serial control word, revolution_signal, reference window, error pump, brake
`timescale 1ns/1ps
// Behaviour
// - internal revolution signal toggles once per revolution by counting zero crossings
// - each revolution signal rising edge starts the reference window, unless the window length is zero
// - window length is the sum of weights 16 to 131072 of low bits
// - speed error is the gap between revolution and window falling edges
// - speed-source bit low selects pole counter, high selects external revolution_signal pin
// - clamp high from startup, dropped at the first error-fast event
// - clamp high means maximum current, filter bypassed and held
// - brake pin or brake bit turns sources off and sinks on
// - brake from the pin holds the sinks on until reset
// - chip select high ignores serial clock and data
// - chip select low shifts data into 24-bit register on clock rise
// - sleep/run bit sent last; word latched on chip select rise
// - reset clears every control bit, entering sleep
// - sleep/run bit low sleeps, high runs
// - step-only bit high disables back-emf commutation, startup oscillator only
// - two current-limit bits pick one of four current levels
// - pole codes 00, 10, 11 give 8, 16, 12 poles
// - diagnostic mux routes revolution, thermal, safe, zero-cross signals
// - speed count field is active low, zero bits add weight
// - zero-cross toggle inverts at every crossing
// - reference counter advances on the external oscillator input
// - brake pin active low turns all sinks on
module ssl_ctrl
  import ssl_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic ref_count_clock_i,
  input wire logic zero_cross_toggle_i,
  input wire logic index_i,
  input wire logic brake_n_i,
  input wire logic thermal_i,
  output logic sleep_o,
  output logic step_only_o,
  output logic [1:0] current_limit_sel_o,
  output logic sources_off_o,
  output logic sinks_on_o,
  output logic loop_init_clamp_o,
  output logic pump_up_o,
  output logic pump_down_o,
  output logic error_fast_o,
  output logic revolution_signal_o,
  output logic diag_out_o
);
  // synchronised pins
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  logic sclk_s, cs_n_s, sdi_s, osc_s, zc_s, index_s, brake_n_s, therm_s;
  logic sclk_q, cs_n_q, osc_q, zc_q;
  logic sclk_rise, cs_rise, osc_rise, zc_edge;
  // control word
  logic [CW_W-1:0] shift_reg;
  logic [CW_W-1:0] motor_control_word;
  logic run_bit, brake_bit, speed_source_sel;
  logic [1:0] pole_count_sel, diag_mux_sel;
  logic [SPD_W-1:0] speed_count_field;
  // revolution and window
  logic [ZC_W-1:0] zc_cnt;
  logic revolution_signal_int, rev_sel, rev_q, rev_rise, rev_fall;
  logic [REF_W-1:0] ref_total, ref_cnt;
  logic ref_active, ref_q, ref_fall;
  // error detector
  ssl_err_e err_state, next_err_state;
  logic error_fast;
  logic pin_brake_latch;
  logic diag_sel_val;

  // zero-cross crossings per revolution for a pole code
  function automatic logic [ZC_W-1:0] zc_per_rev(input logic [1:0] code);
    case (code)
      POLE_16: zc_per_rev = ZC_REV_16;
      POLE_12: zc_per_rev = ZC_REV_12;
      default: zc_per_rev = ZC_REV_8; // undefined code runs as 8 poles
    endcase
  endfunction

  // every pin passes two flip-flops first
  assign pin_raw = {thermal_i, brake_n_i, index_i, zero_cross_toggle_i,
                    ref_count_clock_i, sdi_i, cs_n_i, sclk_i};
  ssl_sync2 #(.W(NSYNC), .RST_VAL(SYNC_RESET)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );
  assign {therm_s, brake_n_s, index_s, zc_s, osc_s, sdi_s, cs_n_s, sclk_s} = pin_s;

  // delayed copies for edge detection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      osc_q <= 1'b0;
      zc_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      osc_q <= osc_s;
      zc_q <= zc_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_q;
  assign cs_rise = cs_n_s & ~cs_n_q;
  assign osc_rise = osc_s & ~osc_q;
  assign zc_edge = zc_s ^ zc_q;

  // serial shift register, idle while chip select is high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_reg <= CTRL_RESET;
    end else if (!cs_n_s && sclk_rise) begin
      shift_reg <= {shift_reg[CW_W-2:0], sdi_s};
    end
  end

  // active word loads at the end of the write, cleared by reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      motor_control_word <= CTRL_RESET;
    end else if (cs_rise) begin
      motor_control_word <= shift_reg;
    end
  end

  // field decode
  assign run_bit = motor_control_word[SLEEP_RUN_POS];
  assign brake_bit = motor_control_word[BRAKE_POS];
  assign speed_source_sel = motor_control_word[SPD_SRC_POS];
  assign speed_count_field = motor_control_word[SPD_LSB +: SPD_W];
  assign pole_count_sel = {motor_control_word[POLE_FIRST_POS],
                           motor_control_word[POLE_SECOND_POS]};
  assign diag_mux_sel = {motor_control_word[DIAG_FIRST_POS],
                         motor_control_word[DIAG_SECOND_POS]};

  // internal revolution_signal: toggles after one revolution of crossings
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      zc_cnt <= '0;
      revolution_signal_int <= 1'b0;
    end else if (!run_bit) begin
      zc_cnt <= '0;
      revolution_signal_int <= 1'b0;
    end else if (zc_edge) begin
      if (zc_cnt >= zc_per_rev(pole_count_sel) - 6'h01) begin
        zc_cnt <= '0;
        revolution_signal_int <= ~revolution_signal_int;
      end else begin
        zc_cnt <= zc_cnt + 6'h01;
      end
    end
  end

  // revolution source select and its edges
  assign rev_sel = speed_source_sel ? index_s : revolution_signal_int;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rev_q <= 1'b0;
    end else begin
      rev_q <= rev_sel;
    end
  end
  assign rev_rise = rev_sel & ~rev_q;
  assign rev_fall = ~rev_sel & rev_q;

  // window length: zero bits of the active-low field, weight 16 upward
  assign ref_total = {~speed_count_field, 4'h0};

  // reference window counter on oscillator rising edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_cnt <= '0;
      ref_active <= 1'b0;
    end else if (rev_rise) begin
      ref_cnt <= ref_total;
      ref_active <= (ref_total != '0);
    end else if (ref_active && osc_rise) begin
      ref_cnt <= ref_cnt - 18'h00001;
      if (ref_cnt == 18'h00001) begin
        ref_active <= 1'b0;
      end
    end
  end

  // window falling edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_active;
    end
  end
  assign ref_fall = ref_q & ~ref_active;

  // error detector next state from the order of falling edges
  always_comb begin
    next_err_state = err_state;
    case (err_state)
      ERR_IDLE: begin
        if (rev_rise && ref_total != '0) begin
          next_err_state = ERR_ARMED; // empty window measures nothing
        end
      end
      ERR_ARMED: begin
        if (rev_fall && ref_fall) begin
          next_err_state = ERR_IDLE;
        end else if (ref_fall) begin
          next_err_state = ERR_UP;
        end else if (rev_fall) begin
          next_err_state = ERR_DOWN;
        end
      end
      ERR_UP: begin
        if (rev_fall) begin
          next_err_state = ERR_IDLE;
        end
      end
      ERR_DOWN: begin
        if (ref_fall || rev_rise) begin
          next_err_state = ERR_IDLE;
        end
      end
      default: next_err_state = ERR_IDLE;
    endcase
  end
  assign error_fast = (err_state == ERR_ARMED) && rev_fall && !ref_fall;

  // error state and pump outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_state <= ERR_IDLE;
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
      error_fast_o <= 1'b0;
    end else if (!run_bit) begin
      err_state <= ERR_IDLE;
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
      error_fast_o <= 1'b0;
    end else begin
      err_state <= next_err_state;
      pump_up_o <= (next_err_state == ERR_UP);
      pump_down_o <= (next_err_state == ERR_DOWN);
      error_fast_o <= error_fast;
    end
  end

  // loop clamp: set in sleep and at startup, dropped at first error-fast
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_init_clamp_o <= 1'b1;
    end else if (!run_bit) begin
      loop_init_clamp_o <= 1'b1;
    end else if (error_fast) begin
      loop_init_clamp_o <= 1'b0;
    end
  end

  // pin brake is sticky until reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_brake_latch <= 1'b0;
    end else if (!brake_n_s) begin
      pin_brake_latch <= 1'b1;
    end
  end

  // brake drive: sources off, sinks on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sources_off_o <= 1'b0;
      sinks_on_o <= 1'b0;
    end else begin
      sources_off_o <= brake_bit | pin_brake_latch | ~brake_n_s;
      sinks_on_o <= brake_bit | pin_brake_latch | ~brake_n_s;
    end
  end

  // mode outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleep_o <= 1'b1;
      step_only_o <= 1'b0;
      current_limit_sel_o <= 2'h0;
    end else begin
      sleep_o <= ~run_bit;
      step_only_o <= motor_control_word[STEP_ONLY_POS];
      current_limit_sel_o <= {motor_control_word[ILIM_FIRST_POS],
                              motor_control_word[ILIM_SECOND_POS]};
    end
  end

  // diagnostic mux; safe signal is the active reference window
  always_comb begin
    case (diag_mux_sel)
      DIAG_REV: diag_sel_val = rev_sel;
      DIAG_THERM: diag_sel_val = therm_s;
      DIAG_SAFE: diag_sel_val = ref_active;
      DIAG_ZC: diag_sel_val = zc_s;
      default: diag_sel_val = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_out_o <= 1'b0;
      revolution_signal_o <= 1'b0;
    end else begin
      diag_out_o <= diag_sel_val;
      revolution_signal_o <= rev_sel;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_shift_in: assert property (!cs_n_s && sclk_rise |=>
    shift_reg == {$past(shift_reg[CW_W-2:0]), $past(sdi_s)})
    else $error("shift register did not take data in");
  a_cs_ignore: assert property (cs_n_s && !$rose(cs_n_s) |=>
    $stable(shift_reg) && $stable(motor_control_word))
    else $error("state changed with chip select high");
  a_word_latch: assert property (cs_rise |=> motor_control_word == $past(shift_reg))
    else $error("word not latched on chip select rise");
  a_ref_len: assert property (rev_rise && ref_total != '0 |=>
    ref_active && ref_cnt == $past(ref_total))
    else $error("reference window length wrong");
  a_pump_up: assert property (run_bit && err_state == ERR_ARMED && ref_fall && !rev_fall
    |=> pump_up_o ##0 err_state == ERR_UP)
    else $error("speed-up request missing");
  a_pump_down: assert property (run_bit && error_fast |=> pump_down_o && error_fast_o)
    else $error("slow-down request missing");
  a_clamp_drop: assert property (run_bit && error_fast ##1 run_bit |->
    !loop_init_clamp_o)
    else $error("clamp not dropped at error-fast");
  a_brake_hold: assert property (!brake_n_s |=> ##1 sinks_on_o [*8])
    else $error("pin brake not held");
  a_index_src: assert property (speed_source_sel |=>
    revolution_signal_o == $past(index_s))
    else $error("index source not used");
  a_sleep_mode: assert property (##1 sleep_o == !$past(run_bit))
    else $error("sleep output wrong");
  a_diag_zc: assert property (diag_mux_sel == DIAG_ZC |=> diag_out_o == $past(zc_s))
    else $error("diag mux zero-cross wrong");

  c_word_write: cover property (cs_rise && shift_reg[SLEEP_RUN_POS]);
  c_slow: cover property (err_state == ERR_UP);
  c_fast: cover property (error_fast);
  c_brake: cover property (pin_brake_latch && sinks_on_o);
endmodule

// ===== logic/ssl_pkg.sv
// constants shared by the spindle speed loop serial control block
package ssl_pkg;
  // control word layout
  localparam int CW_W = 24;
  localparam logic [23:0] CTRL_RESET = 24'h00_0000;
  localparam int SLEEP_RUN_POS = 0;
  localparam int STEP_ONLY_POS = 1;
  localparam int BRAKE_POS = 2;
  localparam int ILIM_FIRST_POS = 3;
  localparam int ILIM_SECOND_POS = 4;
  localparam int SPD_LSB = 5;
  localparam int SPD_W = 14;
  localparam int SPD_SRC_POS = 19;
  localparam int POLE_FIRST_POS = 20;
  localparam int POLE_SECOND_POS = 21;
  localparam int DIAG_FIRST_POS = 22;
  localparam int DIAG_SECOND_POS = 23;
  // reference window: lowest speed bit weighs 16 oscillator cycles
  localparam int REF_W = 18;
  localparam int REF_WEIGHT_SHIFT = 4;
  // pole codes, written as {first bit, second bit}
  localparam logic [1:0] POLE_8 = 2'h0;
  localparam logic [1:0] POLE_16 = 2'h2;
  localparam logic [1:0] POLE_12 = 2'h3;
  // zero crossings per revolution: three per pole
  localparam int ZC_W = 6;
  localparam logic [5:0] ZC_REV_8 = 6'h18;
  localparam logic [5:0] ZC_REV_16 = 6'h30;
  localparam logic [5:0] ZC_REV_12 = 6'h24;
  // diagnostic mux codes, written as {first bit, second bit}
  localparam logic [1:0] DIAG_REV = 2'h0;
  localparam logic [1:0] DIAG_THERM = 2'h1;
  localparam logic [1:0] DIAG_SAFE = 2'h2;
  localparam logic [1:0] DIAG_ZC = 2'h3;
  // synchroniser reset values for the eight pin inputs
  localparam int NSYNC = 8;
  localparam logic [7:0] SYNC_RESET = 8'h42;
  // error detector states
  typedef enum logic [1:0] {ERR_IDLE, ERR_ARMED, ERR_UP, ERR_DOWN} ssl_err_e;
endpackage

// ===== logic/ssl_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ssl_sync2 #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ===== sim/ssl_host_model.sv
// host model driving the three-wire serial control port
`timescale 1ns/1ps
module ssl_host_model (
  input wire logic clk_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // idle: deselected, clock low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // whole word, top bit first; each clock level held 4 clocks, each data bit 8
  task automatic send(input logic [23:0] w);
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_o <= w[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~w[0]; // released line shows no stale level
    repeat (10) @(posedge clk_i);
  endtask
  // clock and data activity while deselected
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= ~sclk_o;
      sdi_o <= ~sdi_o;
    end
  endtask
endmodule

// ===== sim/tb_spindle_speed_loop_serial_ctrl.sv
// self-checking bench for the spindle speed loop serial control block
`timescale 1ns/1ps
module tb_spindle_speed_loop_serial_ctrl;
  import ssl_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sclk, cs_n, sdi;
  logic ref_count_clock_i = 1'b0;
  logic zero_cross_toggle_i = 1'b0;
  logic index_i = 1'b0;
  logic brake_n_i = 1'b1;
  logic thermal_i = 1'b0;
  logic sleep_o, step_only_o, sources_off_o, sinks_on_o, loop_init_clamp_o;
  logic pump_up_o, pump_down_o, error_fast_o, revolution_signal_o, diag_out_o;
  logic [1:0] current_limit_sel_o;
  logic fast_seen = 1'b0;
  logic last;
  logic [1:0] poles [3] = '{POLE_8, POLE_16, POLE_12};
  int pole_n [3] = '{8, 16, 12};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int first, gap;

  always #50 clk_i = ~clk_i;
  // reference oscillator, 800 ns, toggled on clock edges
  always begin
    repeat (4) @(posedge clk_i);
    ref_count_clock_i <= ~ref_count_clock_i;
  end

  ssl_host_model host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

  ssl_ctrl dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .ref_count_clock_i(ref_count_clock_i),
    .zero_cross_toggle_i(zero_cross_toggle_i), .index_i(index_i), .brake_n_i(brake_n_i),
    .thermal_i(thermal_i), .sleep_o(sleep_o), .step_only_o(step_only_o),
    .current_limit_sel_o(current_limit_sel_o), .sources_off_o(sources_off_o),
    .sinks_on_o(sinks_on_o), .loop_init_clamp_o(loop_init_clamp_o), .pump_up_o(pump_up_o),
    .pump_down_o(pump_down_o), .error_fast_o(error_fast_o),
    .revolution_signal_o(revolution_signal_o), .diag_out_o(diag_out_o));

  // catches the one-cycle error-fast pulse; cuts a hang short
  always @(posedge clk_i) begin
    if (error_fast_o === 1'b1) fast_seen <= 1'b1;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // control word from fields; low3 is {brake, step, run}, pairs are {first, second}
  function automatic logic [23:0] word(input logic [1:0] diag, input logic [1:0] pole,
      input logic src, input logic [13:0] spd, input logic [1:0] ilim, input logic [2:0] low3);
    logic [23:0] v;
    v = 24'h0;
    v[2:0] = low3;
    {v[ILIM_FIRST_POS], v[ILIM_SECOND_POS]} = ilim;
    v[SPD_LSB +: SPD_W] = spd;
    v[SPD_SRC_POS] = src;
    {v[POLE_FIRST_POS], v[POLE_SECOND_POS]} = pole;
    {v[DIAG_FIRST_POS], v[DIAG_SECOND_POS]} = diag;
    return v;
  endfunction

  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({sleep_o, loop_init_clamp_o}, 2'h3);
    check({step_only_o, current_limit_sel_o, sources_off_o, sinks_on_o}, 24'h0);
    // run, step-only, every current-limit code
    for (int c = 0; c < 4; c++) begin
      host.send(word(DIAG_REV, POLE_8, 1'b0, 14'h3fff, c[1:0], 3'h3));
      check({sleep_o, step_only_o}, 2'h1);
      check(current_limit_sel_o, c[1:0]);
    end
    host.noise();
    repeat (10) @(posedge clk_i);
    check(current_limit_sel_o, 2'h3);
    // brake bit with thermal flag on the diagnostic output
    host.send(word(DIAG_THERM, POLE_8, 1'b0, 14'h3fff, 2'h0, 3'h5));
    check({sources_off_o, sinks_on_o, step_only_o}, 3'h6);
    thermal_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(diag_out_o, 1'b1);
    thermal_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(diag_out_o, 1'b0);
    host.send(word(DIAG_REV, POLE_8, 1'b0, 14'h3fff, 2'h0, 3'h0));
    check({sleep_o, sources_off_o, sinks_on_o}, 3'h4);
    // internal revolution_signal: crossings per revolution for each pole code
    for (int p = 0; p < 3; p++) begin
      host.send(word(DIAG_ZC, poles[p], 1'b0, 14'h3fff, 2'h0, 3'h1));
      first = -1;
      gap = 0;
      last = revolution_signal_o;
      for (int e = 1; e <= 150 && gap == 0; e++) begin
        zero_cross_toggle_i <= ~zero_cross_toggle_i;
        repeat (6) @(posedge clk_i);
        check(diag_out_o, zero_cross_toggle_i);
        if (revolution_signal_o !== last) begin
          if (first >= 0) gap = e - first;
          first = e;
          last = revolution_signal_o;
        end
      end
      check(gap, 3 * pole_n[p]);
    end
    // external revolution_signal, window of 16 oscillator cycles, written while loop idle
    host.send(word(DIAG_REV, POLE_8, 1'b1, 14'h3ffe, 2'h0, 3'h1));
    index_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({revolution_signal_o, diag_out_o}, 2'h3);
    repeat (104) @(posedge clk_i);
    check({pump_up_o, loop_init_clamp_o}, 2'h1);
    repeat (35) @(posedge clk_i);
    check({pump_up_o, pump_down_o}, 2'h2);
    index_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(pump_up_o, 1'b0);
    // revolution falls first: slow-down, error-fast, clamp released
    index_i <= 1'b1;
    repeat (50) @(posedge clk_i);
    index_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({pump_down_o, fast_seen}, 2'h3);
    repeat (150) @(posedge clk_i);
    check({pump_down_o, loop_init_clamp_o}, 2'h0);
    // safe signal on the diagnostic output follows the reference window
    host.send(word(DIAG_SAFE, POLE_8, 1'b1, 14'h3ffe, 2'h0, 3'h1));
    index_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(diag_out_o, 1'b1);
    repeat (140) @(posedge clk_i);
    check({diag_out_o, pump_up_o}, 2'h1);
    index_i <= 1'b0;
    // brake pin holds sinks until reset
    brake_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({sources_off_o, sinks_on_o}, 2'h3);
    brake_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(sinks_on_o, 1'b1);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({sleep_o, sinks_on_o, loop_init_clamp_o}, 3'h5);
    summarize();
  end
endmodule
